// File: hdl/hpb_addr_latch.sv
// Purpose : holds the word address of the current host access
// Assumes : inputs synchronous to clk_i
// Notes   : split mode latches on select fall, muxed mode while the latch strobe is high
`include "hpb_params.svh"
`default_nettype none

module hpb_addr_latch
(
   input  wire logic              clk_i,        // 25 MHz clock
   input  wire logic              rst_i,        // sync reset, high
   input  wire logic              mode_i,       // caught strap
   input  wire logic              sel_fall_i,   // select fell this cycle
   input  wire logic [3:0]        addr_pins_i,  // address lines 5..2
   input  wire logic              latch_stb_i,  // muxed latch strobe
   input  wire hpb_pkg::hpb_addr_t muxed_i,     // data pins 5..2
   output var  hpb_pkg::hpb_addr_t addr_o       // held word address
);
   import hpb_pkg::*;

   hpb_addr_t addr_q;   // held address
   hpb_addr_t addr_d;   // next address

   // ----------------------------------------
   // next address
   // ----------------------------------------
   always_comb
   begin
      addr_d = addr_q;
      if (mode_i == `HPB_MODE_SPLIT)
      begin
         // lowest pin is bit 2, words are 32-bit aligned
         if (sel_fall_i)
            addr_d = addr_pins_i;
      end
      else
      begin
         // address pins, bit 4 among them, are ignored here
         if (latch_stb_i)
            addr_d = muxed_i;
      end
   end

   // ----------------------------------------
   // register
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         addr_q <= `HPB_ADDR_RST;
      else
         addr_q <= addr_d;
   end

   assign addr_o = addr_q;
endmodule : hpb_addr_latch

`default_nettype wire

// File: hdl/hpb_port.sv
// Purpose : device end of the host parallel bus, pins to a simple word port
// Assumes : host pins synchronous to clk_i; core answers a read in the cycle it is asked
// Notes   : strap caught once after reset release; data pins split into in/out/enable
//
// Notes on behaviour
// - drive data pins only while enable low
// - write strobe low writes, high reads
// - mux select 0: shared pins pure data
// - mux select 1: low pins address then data
// - split mode: catch bit 4 at select fall
// - mux select 1: ignore address line bit 4
// - full 32-bit bidirectional data bus
// - mux select 1: address bit 2 pin latches
// - word aligned, lowest address bit is 2
`include "hpb_params.svh"
`default_nettype none

module hpb_port
(
   input  wire logic               clk_i,                  // 25 MHz clock
   input  wire logic               rst_i,                  // sync reset, high
   // ----- host pins -----
   input  wire logic               bus_mux_select_i,       // strap, 1 = muxed
   input  wire logic               host_select_n_i,        // chip select, low
   input  wire logic               host_drive_enable_n_i,  // output enable, low
   input  wire logic               host_write_strobe_n_i,  // low write, high read
   input  wire logic               addr_line_bit2_i,       // bit 2, or latch strobe when muxed
   input  wire logic               addr_line_bit3_i,       // bit 3, unused when muxed
   input  wire logic               addr_line_bit4_i,       // bit 4, unused when muxed
   input  wire logic               addr_line_bit5_i,       // bit 5, unused when muxed
   input  wire hpb_pkg::hpb_data_t data_in_i,              // data pins as seen
   output var  hpb_pkg::hpb_data_t data_out_o,             // data pins driven value
   output logic [`HPB_DATA_W-1:0]  data_oe_n_o,            // per pin, low = drive
   // ----- core side -----
   output var  hpb_pkg::hpb_addr_t acc_addr_o,             // word address
   output logic                    acc_rd_o,               // read request pulse
   input  wire hpb_pkg::hpb_data_t acc_rdata_i,            // read word, same cycle
   output logic                    acc_wr_o,               // write pulse
   output var  hpb_pkg::hpb_data_t acc_wdata_o,            // write word
   output logic                    mux_mode_o              // caught strap
);
   import hpb_pkg::*;

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic       mode_q, mode_d;          // caught bus mode
   logic       caught_q, caught_d;      // strap taken
   logic       sel_q, sel_d;            // select last cycle
   hpb_state_e state_q, state_d;        // access state
   hpb_data_t  rdat_q, rdat_d;          // read word for pins
   hpb_data_t  wdat_q, wdat_d;          // write word
   logic       rd_q, rd_d;              // read pulse
   logic       wr_q, wr_d;              // write pulse
   logic       sel_fall;                // select just went low
   logic       sel_rise;                // select just went high
   logic       drive;                   // pins driven now

   assign sel_fall = sel_q & ~host_select_n_i;
   assign sel_rise = ~sel_q & host_select_n_i;

   // ----------------------------------------
   // strap and edge state
   // ----------------------------------------
   // strap is caught after release, never loaded under reset
   always_comb
   begin
      mode_d   = mode_q;
      caught_d = 1'b1;
      sel_d    = host_select_n_i;
      if (!caught_q)
         mode_d = bus_mux_select_i;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mode_q   <= `HPB_MODE_RST;
         caught_q <= 1'b0;
         sel_q    <= 1'b1;
      end
      else
      begin
         mode_q   <= mode_d;
         caught_q <= caught_d;
         sel_q    <= sel_d;
      end
   end

   // ----------------------------------------
   // address capture
   // ----------------------------------------
   hpb_addr_latch u_addr
   (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .mode_i      (mode_q),
      .sel_fall_i  (sel_fall),
      .addr_pins_i ({addr_line_bit5_i, addr_line_bit4_i, addr_line_bit3_i, addr_line_bit2_i}),
      .latch_stb_i (addr_line_bit2_i),
      .muxed_i     (data_in_i[`HPB_ADDR_MSB:`HPB_ADDR_LSB]),
      .addr_o      (acc_addr_o)
   );

   // ----------------------------------------
   // access sequencing
   // ----------------------------------------
   // a select that rises before the drive state ends a read without driving the pins; the read pulse is still sent
   always_comb
   begin
      state_d = state_q;
      rdat_d  = rdat_q;
      wdat_d  = wdat_q;
      rd_d    = 1'b0;
      wr_d    = 1'b0;
      case (state_q)
         HPB_IDLE:
         begin
            if (sel_fall && caught_q)
            begin
               if (host_write_strobe_n_i)   // high asks a read
               begin
                  rd_d    = 1'b1;
                  state_d = HPB_RD_FETCH;
               end
               else                         // low asks a write
               begin
                  wdat_d  = data_in_i;
                  state_d = HPB_WR_TAKE;
               end
            end
         end
         HPB_RD_FETCH:
         begin
            rdat_d  = acc_rdata_i;          // all 32 bits
            state_d = host_select_n_i ? HPB_IDLE : HPB_RD_DRIVE;
         end
         HPB_RD_DRIVE:
         begin
            if (host_select_n_i)
               state_d = HPB_IDLE;
         end
         HPB_WR_TAKE:
         begin
            // last sample before select rises wins; muxed data phase
            // replaces the address bits on the shared pins
            if (!host_select_n_i && !host_write_strobe_n_i)
               wdat_d = data_in_i;
            if (sel_rise)
            begin
               wr_d    = 1'b1;
               state_d = HPB_IDLE;
            end
         end
         default:
         begin
            state_d = HPB_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_q <= HPB_IDLE;
         rdat_q  <= `HPB_DATA_RST;
         wdat_q  <= `HPB_DATA_RST;
         rd_q    <= 1'b0;
         wr_q    <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         rdat_q  <= rdat_d;
         wdat_q  <= wdat_d;
         rd_q    <= rd_d;
         wr_q    <= wr_d;
      end
   end

   // ----------------------------------------
   // pin drive
   // ----------------------------------------
   // enable is combinational so the pins release the cycle enable rises
   assign drive = (state_q == HPB_RD_DRIVE) && !host_select_n_i && !host_drive_enable_n_i;

   genvar gi;
   generate
      for (gi = 0; gi < `HPB_DATA_W; gi = gi + 1)
      begin : g_pin
         // every pin is pure data in either mode on the drive side
         assign data_oe_n_o[gi] = ~drive;
      end
   endgenerate

   assign data_out_o  = rdat_q;
   assign acc_rd_o    = rd_q;
   assign acc_wr_o    = wr_q;
   assign acc_wdata_o = wdat_q;
   assign mux_mode_o  = mode_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_sel_fall;
      $past(host_select_n_i) && !host_select_n_i && caught_q && state_q == HPB_IDLE;
   endsequence

   sequence s_read_ask;
      s_sel_fall ##0 host_write_strobe_n_i;
   endsequence

   AST_DRIVE_ONLY_ENABLED: assert property (data_oe_n_o != '1 |-> !host_drive_enable_n_i)
      else $error("data pins driven while enable high");

   AST_READ_DIR: assert property (s_read_ask |=> acc_rd_o ##1 !acc_rd_o)
      else $error("read not asked once for strobe high");

   AST_WRITE_DIR: assert property (s_sel_fall ##0 !host_write_strobe_n_i |=> !acc_rd_o)
      else $error("write access produced a read");

   // split mode: the address comes from the address lines, never the shared data pins
   AST_SPLIT_DATA: assert property (!mode_q && $fell(host_select_n_i) |=>
      acc_addr_o == $past({addr_line_bit5_i, addr_line_bit4_i, addr_line_bit3_i, addr_line_bit2_i}))
      else $error("split mode address not from address lines");

   AST_MUX_ADDR: assert property (mode_q && addr_line_bit2_i |=> acc_addr_o == $past(data_in_i[5:2]))
      else $error("muxed address not taken from data pins");

   AST_SPLIT_BIT4: assert property (!mode_q && $fell(host_select_n_i) |=> acc_addr_o[2] == $past(addr_line_bit4_i))
      else $error("address bit 4 not caught at select fall");

   AST_MUX_IGNORE_BIT4: assert property (mode_q && !addr_line_bit2_i |=> $stable(acc_addr_o))
      else $error("address moved without latch strobe");

   AST_FULL_WORD: assert property (s_read_ask ##1 1'b1 |=> rdat_q == $past(acc_rdata_i))
      else $error("read word not held whole");

   AST_LATCH_PIN: assert property (mode_q && !addr_line_bit2_i && $fell(host_select_n_i) |=> $stable(acc_addr_o))
      else $error("muxed select fall disturbed address");

   AST_WORD_ALIGN: assert property (!mode_q && $fell(host_select_n_i) |=> acc_addr_o[0] == $past(addr_line_bit2_i))
      else $error("lowest address bit is not bit 2");
endmodule : hpb_port

`default_nettype wire

// File: include/hpb_params.svh
// Purpose : constants for the host parallel bus pin block
// Assumes : included by bare name before use
// Notes   : timing counts are not needed, the bus is sampled each clock
`ifndef HPB_PARAMS_SVH
`define HPB_PARAMS_SVH

// ----------------------------------------
// field positions and widths
// ----------------------------------------
`define HPB_DATA_W      32        // host data bus width
`define HPB_ADDR_LSB    2         // lowest address bit on the bus
`define HPB_ADDR_MSB    5         // highest address bit on the bus
`define HPB_ADDR_W      4         // address bits 5 down to 2

// ----------------------------------------
// strap encodings and reset values
// ----------------------------------------
`define HPB_MODE_SPLIT  1'b0      // separate address lines
`define HPB_MODE_MUXED  1'b1      // low data pins also carry address
`define HPB_MODE_RST    1'b0      // mode before the strap is caught
`define HPB_DATA_RST    32'h0000_0000
`define HPB_ADDR_RST    4'h0

`endif

// File: include/hpb_pkg.sv
// Purpose : types shared by the host parallel bus pin block
// Assumes : hpb_params.svh defines the widths
// Notes   : state enum carries no codes
`include "hpb_params.svh"
`default_nettype none

package hpb_pkg;
   typedef logic [`HPB_DATA_W-1:0] hpb_data_t;   // one bus word
   typedef logic [`HPB_ADDR_W-1:0] hpb_addr_t;   // word address
   typedef enum logic [1:0]
   {
      HPB_IDLE,      // no access in progress
      HPB_RD_FETCH,  // read asked of the core side
      HPB_RD_DRIVE,  // read word ready for the pins
      HPB_WR_TAKE    // write data being sampled
   } hpb_state_e;
endpackage : hpb_pkg

`default_nettype wire

// File: sim/hpb_host_model.sv
// Purpose : host processor model driving the parallel bus pins
// Assumes : pins change 1 ns after the rising clock edge
// Notes   : released data lines show the inverse of the last value
`default_nettype none

module hpb_host_model
(
   input  wire  logic               clk_i,    // bus clock
   input  wire  logic               mode_i,   // 1 = muxed bus
   input  wire  hpb_pkg::hpb_data_t bus_i,    // resolved data lines
   output logic                     sel_n_o,  // chip select, low
   output logic                     oe_n_o,   // output enable, low
   output logic                     we_n_o,   // low write, high read
   output logic [3:0]               a_o,      // pins 5..2, bit 0 latch strobe when muxed
   output var   hpb_pkg::hpb_data_t d_o       // value put on the data lines
);
   timeunit 1ns;
   timeprecision 1ns;
   import hpb_pkg::*;

   // ----------------------------------------
   // idle levels
   // ----------------------------------------
   initial
   begin
      sel_n_o = 1'b1;
      oe_n_o  = 1'b1;
      we_n_o  = 1'b1;
      a_o     = 4'h0;
      d_o     = 32'h0000_0000;
   end

   // one whole access; address pins turn to junk once the select fall is past
   task automatic acc(input hpb_addr_t a, input logic wr, input logic en, input hpb_data_t wd,
                      output hpb_data_t rd);
      @(posedge clk_i) #1;
      if (mode_i)
      begin
         a_o = {~a[3:1], 1'b1};
         d_o = {wd[31:6], a, wd[1:0]};
         @(posedge clk_i) #1;
         a_o[0] = 1'b0;
      end
      else
         a_o = a;
      sel_n_o = 1'b0;
      we_n_o  = ~wr;
      oe_n_o  = wr | ~en;
      d_o     = wr ? wd : ~d_o;
      @(posedge clk_i) #1;
      a_o = {~a[3:1], mode_i ? 1'b0 : ~a[0]};
      repeat (3) @(posedge clk_i);
      #1 rd = bus_i;
      sel_n_o = 1'b1;
      oe_n_o  = 1'b1;
      we_n_o  = 1'b1;
      d_o     = ~d_o;
   endtask : acc
endmodule : hpb_host_model

`default_nettype wire

// File: sim/hpb_port_tb.sv
// Purpose : self-checking bench for the host parallel bus pin block
// Assumes : core answers reads in the same cycle
// Notes   : both strap settings are run, each after its own reset
`default_nettype none

module hpb_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import hpb_pkg::*;

   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic       clk_i = 1'b0;     // 25 MHz clock
   logic       rst_i = 1'b1;     // sync reset
   logic       strap = 1'b0;     // bus mode strap
   logic       sel_n, oe_n, we_n; // host strobes
   logic [3:0] a_p;              // address pins
   hpb_data_t  h_d, bus, d_out, rdat, wdat;
   logic [31:0] oe_n_v;          // per pin enables
   hpb_addr_t  acc_a;            // core address
   logic       rd_p, wr_p, mode; // core pulses, caught strap
   int         error_cnt = 0;
   int         n_checks = 0;
   int         wr_n = 0, rd_n = 0, bad = 0;
   logic       drove;            // device drove in this access
   hpb_addr_t  wr_a;             // address seen with write pulse
   hpb_data_t  wr_d;             // data seen with write pulse

   always #20 clk_i = ~clk_i;

   // read word a core would give; own pattern, not the design's
   function automatic hpb_data_t word_of(input hpb_addr_t a);
      return {~a, 24'hc35a96, a};
   endfunction : word_of

   assign rdat = word_of(acc_a);
   assign bus  = (~oe_n_v & d_out) | (oe_n_v & h_d);

   hpb_host_model host_u (.clk_i(clk_i), .mode_i(strap), .bus_i(bus), .sel_n_o(sel_n), .oe_n_o(oe_n),
                          .we_n_o(we_n), .a_o(a_p), .d_o(h_d));

   hpb_port dut_u (.clk_i(clk_i), .rst_i(rst_i), .bus_mux_select_i(strap), .host_select_n_i(sel_n),
                   .host_drive_enable_n_i(oe_n), .host_write_strobe_n_i(we_n),
                   .addr_line_bit2_i(a_p[0]), .addr_line_bit3_i(a_p[1]), .addr_line_bit4_i(a_p[2]),
                   .addr_line_bit5_i(a_p[3]), .data_in_i(bus), .data_out_o(d_out),
                   .data_oe_n_o(oe_n_v), .acc_addr_o(acc_a), .acc_rd_o(rd_p), .acc_rdata_i(rdat),
                   .acc_wr_o(wr_p), .acc_wdata_o(wdat), .mux_mode_o(mode));

   // ----------------------------------------
   // monitors of the core side and pins
   // ----------------------------------------
   always @(posedge clk_i)
   begin
      if (wr_p === 1'b1)
      begin
         wr_n++;
         wr_a = acc_a;
         wr_d = wdat;
      end
      if (rd_p === 1'b1)
         rd_n++;
      if (oe_n_v !== 32'hffff_ffff)
         drove = 1'b1;
      if (oe_n_v !== 32'hffff_ffff && oe_n !== 1'b0)
         bad++;
   end

   // ----------------------------------------
   // compare tasks and closing
   // ----------------------------------------
   task automatic chk_word(input hpb_data_t got, input hpb_data_t exp);
      n_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: word %h, expected %h", $time, got, exp);
      end
   endtask : chk_word

   task automatic chk_addr(input hpb_addr_t got, input hpb_addr_t exp);
      n_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: address %h, expected %h", $time, got, exp);
      end
   endtask : chk_addr

   task automatic chk_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: flag %b, expected %b", $time, got, exp);
      end
   endtask : chk_bit

   task automatic end_of_test;
      $display("checks %0d, mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test

   // reset with a strap value, then look at idle outputs
   task automatic do_reset(input logic m);
      #1 strap = m;
      rst_i = 1'b1;
      repeat (16) @(posedge clk_i);
      #1 chk_word(oe_n_v, 32'hffff_ffff);
      rst_i = 1'b0;
      repeat (3) @(posedge clk_i);
      #1 chk_bit(mode, m);
   endtask : do_reset

   // write then read back at addresses that flip every address bit
   task automatic t_walk(input logic m);
      hpb_data_t rd, wd;
      hpb_addr_t a;
      int w0, r0;
      do_reset(m);
      for (int i = 0; i < 4; i++)
      begin
         a = hpb_addr_t'(i * 5);
         wd = ~word_of(a) ^ 32'h8000_0001;
         w0 = wr_n;
         host_u.acc(a, 1'b1, 1'b0, wd, rd);
         repeat (4) @(posedge clk_i);
         #1 chk_bit(wr_n - w0 == 1, 1'b1);
         chk_addr(wr_a, a);
         chk_word(wr_d, wd);
         r0 = rd_n;
         drove = 1'b0;
         host_u.acc(a, 1'b0, 1'b1, 32'h0000_0000, rd);
         chk_bit(rd_n - r0 == 1, 1'b1);
         chk_addr(acc_a, a);
         chk_word(rd, word_of(a));
         chk_bit(drove, 1'b1);
         @(posedge clk_i) #1;
         chk_word(oe_n_v, 32'hffff_ffff);
      end
      $display("walk test done, mode %b", m);
   endtask : t_walk

   // read with the host enable left high: pins must stay undriven
   task automatic t_no_enable;
      hpb_data_t rd;
      drove = 1'b0;
      host_u.acc(4'h9, 1'b0, 1'b0, 32'h0000_0000, rd);
      chk_bit(drove, 1'b0);
      chk_bit(bad == 0, 1'b1);
      $display("no enable test done");
   endtask : t_no_enable

   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial
   begin
      t_walk(1'b0);
      t_no_enable();
      t_walk(1'b1);
      t_no_enable();
      end_of_test();
   end

   initial
   begin
      #(40 * 5000);
      error_cnt++;
      $display("CHECK FAILED at %0t: watchdog ran out", $time);
      end_of_test();
   end
endmodule : hpb_port_tb

`default_nettype wire
